// ==== rtl/pca_params.svh ====
// Register offsets, field positions and reset values of the counter array
`ifndef PCA_PARAMS_SVH
`define PCA_PARAMS_SVH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define OFS_MODE       8'h00
`define OFS_CNT_LO     8'h04
`define OFS_CNT_HI     8'h08
`define OFS_STATUS     8'h0c
`define OFS_MASK       8'h10
`define OFS_CMP0       8'h14
`define OFS_CMP1       8'h18
`define OFS_CMP2       8'h1c

// ------------------------------------------------------------------
// Mode register fields
// ------------------------------------------------------------------
`define MODE_TBSEL_LSB 0
`define MODE_IDLE_BIT  3
`define MODE_WDT_BIT   4
`define MODE_ARRAY_BIT 5
`define MODE_GLOB_BIT  6
`define MODE_CHEN_LSB  8

// ------------------------------------------------------------------
// Status and mask fields
// ------------------------------------------------------------------
`define ST_OVF_BIT     0
`define ST_CH_LSB      1

// ------------------------------------------------------------------
// Timebase divisors and reset values
// ------------------------------------------------------------------
`define PRESC_LAST     4'hb
`define DIV4_LAST      2'h3
`define WDT_RST_VAL    1'h1
`define CNT_MAX        16'hffff

`endif

// ==== rtl/pca_pkg.sv ====
// Types shared by the counter array design
package pca_pkg;

    // ------------------------------------------------------------------
    // Timebase selection codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        TB_SYS_DIV12 = 3'h0,
        TB_SYS_DIV4  = 3'h1,
        TB_T0_OVF    = 3'h2,
        TB_EXT_FALL  = 3'h3,
        TB_SYS       = 3'h4,
        TB_OSC_DIV8  = 3'h5
    } timebase_e;

    // ------------------------------------------------------------------
    // Complete state of the block
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]       ext_sync;
        logic             ext_prev;
        logic [1:0]       osc_sync;
        logic             osc_prev;
        logic [3:0]       presc;
        logic [15:0]      count;
        logic [7:0]       snap;
        logic [2:0]       tbsel;
        logic             idle_hold;
        logic             wdt_en;
        logic             array_en;
        logic             global_en;
        logic [3:0]       status;
        logic [3:0]       mask;
        logic [2:0]       chan_en;
        logic [2:0][15:0] cmp;
        logic [2:0]       io;
        logic             wdt_rst;
        logic             req;
        logic             irq;
        logic             awready;
        logic             wready;
        logic             aw_got;
        logic             w_got;
        logic [7:0]       awaddr;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             arready;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } pca_state_s;

endpackage : pca_pkg

// ==== rtl/pca_counter_timebase_irq.sv ====
// Counter array core: 16-bit timebase counter, compare channels, interrupt tree
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps

`include "pca_params.svh"

module pca_counter_timebase_irq
    import pca_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Timebase sources
    input  wire logic        ext_count_input,
    input  wire logic        ext_osc_div8,
    input  wire logic        timer0_ovf,
    // Processor state
    input  wire logic        cpu_idle,
    // Channel lines and interrupt outputs
    output logic [2:0]       channel_io_line,
    output logic [2:0]       channel_io_oe,
    output logic             array_irq_req,
    output logic             cpu_irq,
    output logic             wdt_reset
);

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    pca_state_s s_r;
    pca_state_s s_nxt;

    logic        tick;
    logic        wr_fire;
    logic        rd_fire;
    logic [15:0] cnt_inc;
    logic [1:0]  cmp_idx;
    logic [31:0] rd_word;
    logic        rd_ok;
    logic        wr_ok;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r         <= '0;
            s_r.wdt_en  <= `WDT_RST_VAL;
            s_r.awready <= 1'h1;
            s_r.wready  <= 1'h1;
            s_r.arready <= 1'h1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt   = s_r;
        tick    = 1'h0;
        cnt_inc = s_r.count + 16'h0001;
        cmp_idx = 2'h0;
        rd_word = 32'h0;
        rd_ok   = 1'h1;
        wr_ok   = 1'h1;

        // Pin inputs pass two flops; edges are read from the second only
        s_nxt.ext_sync = {s_r.ext_sync[0], ext_count_input};
        s_nxt.ext_prev = s_r.ext_sync[1];
        s_nxt.osc_sync = {s_r.osc_sync[0], ext_osc_div8};
        s_nxt.osc_prev = s_r.osc_sync[1];

        // Free-running prescaler, shared by the /12 and /4 taps
        if (s_r.presc == `PRESC_LAST) begin
            s_nxt.presc = 4'h0;
        end else begin
            s_nxt.presc = s_r.presc + 4'h1;
        end

        // Timebase select; reserved codes give no tick
        case (timebase_e'(s_r.tbsel))
            TB_SYS_DIV12: tick = (s_r.presc == `PRESC_LAST);
            TB_SYS_DIV4:  tick = (s_r.presc[1:0] == `DIV4_LAST);
            TB_T0_OVF:    tick = timer0_ovf;
            TB_EXT_FALL:  tick = s_r.ext_prev & ~s_r.ext_sync[1];
            TB_SYS:       tick = 1'h1;
            TB_OSC_DIV8:  tick = s_r.osc_sync[1] & ~s_r.osc_prev;
            default:      tick = 1'h0;
        endcase

        // Idle hold gates the count; with hold clear Idle has no effect
        if (s_r.idle_hold && cpu_idle) begin
            tick = 1'h0;
        end

        // Counter advance, overflow and channel matches
        s_nxt.wdt_rst = 1'h0;
        if (tick) begin
            s_nxt.count = cnt_inc;
            if (s_r.count == `CNT_MAX) begin
                s_nxt.status[`ST_OVF_BIT] = 1'h1;
            end
            for (int i = 0; i < 3; i++) begin
                if (s_r.chan_en[i] && cnt_inc == s_r.cmp[i]) begin
                    s_nxt.status[`ST_CH_LSB + i] = 1'h1;
                    s_nxt.io[i] = ~s_r.io[i];
                end
            end
            if (s_r.wdt_en && cnt_inc == s_r.cmp[2]) begin
                s_nxt.wdt_rst = 1'h1;
            end
        end

        // ------------------------------------------------------------------
        // AXI write channel
        // ------------------------------------------------------------------
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.awaddr  = s_axi_awaddr;
            s_nxt.aw_got  = 1'h1;
            s_nxt.awready = 1'h0;
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.wdata  = s_axi_wdata;
            s_nxt.wstrb  = s_axi_wstrb;
            s_nxt.w_got  = 1'h1;
            s_nxt.wready = 1'h0;
        end

        wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
        cmp_idx = s_r.awaddr[3:2] - 2'h1;
        if (wr_fire) begin
            s_nxt.aw_got = 1'h0;
            s_nxt.w_got  = 1'h0;
            s_nxt.bvalid = 1'h1;
            case (s_r.awaddr)
                `OFS_MODE: begin
                    if (s_r.wstrb[0]) begin
                        // Watchdog on: only its own enable may change
                        s_nxt.wdt_en = s_r.wdata[`MODE_WDT_BIT];
                        if (!s_r.wdt_en) begin
                            s_nxt.tbsel     = s_r.wdata[`MODE_TBSEL_LSB +: 3];
                            s_nxt.idle_hold = s_r.wdata[`MODE_IDLE_BIT];
                            s_nxt.array_en  = s_r.wdata[`MODE_ARRAY_BIT];
                            s_nxt.global_en = s_r.wdata[`MODE_GLOB_BIT];
                        end
                    end
                    if (s_r.wstrb[1] && !s_r.wdt_en) begin
                        s_nxt.chan_en = s_r.wdata[`MODE_CHEN_LSB +: 3];
                    end
                end
                `OFS_CNT_LO: begin
                    if (s_r.wstrb[0] && !s_r.wdt_en) begin
                        s_nxt.count[7:0] = s_r.wdata[7:0];
                    end
                end
                `OFS_CNT_HI: begin
                    if (s_r.wstrb[0] && !s_r.wdt_en) begin
                        s_nxt.count[15:8] = s_r.wdata[7:0];
                    end
                end
                `OFS_STATUS: begin
                    // Write one to clear; a same-cycle event wins
                    if (s_r.wstrb[0]) begin
                        s_nxt.status = s_r.status & ~s_r.wdata[3:0];
                        if (tick && s_r.count == `CNT_MAX) begin
                            s_nxt.status[`ST_OVF_BIT] = 1'h1;
                        end
                        for (int i = 0; i < 3; i++) begin
                            if (tick && s_r.chan_en[i] && cnt_inc == s_r.cmp[i]) begin
                                s_nxt.status[`ST_CH_LSB + i] = 1'h1;
                            end
                        end
                    end
                end
                `OFS_MASK: begin
                    if (s_r.wstrb[0]) begin
                        s_nxt.mask = s_r.wdata[3:0];
                    end
                end
                `OFS_CMP0, `OFS_CMP1, `OFS_CMP2: begin
                    // Channel 2 compare is locked while it guards the system
                    if (!(s_r.wdt_en && cmp_idx == 2'h2)) begin
                        if (s_r.wstrb[0]) begin
                            s_nxt.cmp[cmp_idx][7:0] = s_r.wdata[7:0];
                        end
                        if (s_r.wstrb[1]) begin
                            s_nxt.cmp[cmp_idx][15:8] = s_r.wdata[15:8];
                        end
                    end
                end
                default: wr_ok = 1'h0;
            endcase
            s_nxt.bresp = wr_ok ? 2'h0 : 2'h2;
        end

        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid  = 1'h0;
            s_nxt.awready = 1'h1;
            s_nxt.wready  = 1'h1;
        end

        // ------------------------------------------------------------------
        // AXI read channel
        // ------------------------------------------------------------------
        rd_fire = s_axi_arvalid && s_r.arready;
        case (s_axi_araddr)
            `OFS_MODE: begin
                rd_word[`MODE_TBSEL_LSB +: 3] = s_r.tbsel;
                rd_word[`MODE_IDLE_BIT]       = s_r.idle_hold;
                rd_word[`MODE_WDT_BIT]        = s_r.wdt_en;
                rd_word[`MODE_ARRAY_BIT]      = s_r.array_en;
                rd_word[`MODE_GLOB_BIT]       = s_r.global_en;
                rd_word[`MODE_CHEN_LSB +: 3]  = s_r.chan_en;
            end
            `OFS_CNT_LO: rd_word[7:0]  = s_r.count[7:0];
            `OFS_CNT_HI: rd_word[7:0]  = s_r.snap;
            `OFS_STATUS: rd_word[3:0]  = s_r.status;
            `OFS_MASK:   rd_word[3:0]  = s_r.mask;
            `OFS_CMP0:   rd_word[15:0] = s_r.cmp[0];
            `OFS_CMP1:   rd_word[15:0] = s_r.cmp[1];
            `OFS_CMP2:   rd_word[15:0] = s_r.cmp[2];
            default:     rd_ok = 1'h0;
        endcase

        if (rd_fire) begin
            s_nxt.arready = 1'h0;
            s_nxt.rvalid  = 1'h1;
            s_nxt.rdata   = rd_word;
            s_nxt.rresp   = rd_ok ? 2'h0 : 2'h2;
            // Latch taken in the same cycle as the low byte, so pair is coherent
            if (s_axi_araddr == `OFS_CNT_LO) begin
                s_nxt.snap = s_r.count[15:8];
            end
        end

        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid  = 1'h0;
            s_nxt.arready = 1'h1;
        end

        // ------------------------------------------------------------------
        // Interrupt tree
        // ------------------------------------------------------------------
        s_nxt.req = |(s_nxt.status & s_nxt.mask);
        s_nxt.irq = s_nxt.req & s_nxt.array_en & s_nxt.global_en;
    end

    // ------------------------------------------------------------------
    // Outputs, all taken from flops
    // ------------------------------------------------------------------
    assign s_axi_awready   = s_r.awready;
    assign s_axi_wready    = s_r.wready;
    assign s_axi_bvalid    = s_r.bvalid;
    assign s_axi_bresp     = s_r.bresp;
    assign s_axi_arready   = s_r.arready;
    assign s_axi_rvalid    = s_r.rvalid;
    assign s_axi_rdata     = s_r.rdata;
    assign s_axi_rresp     = s_r.rresp;
    assign channel_io_line = s_r.io;
    assign channel_io_oe   = s_r.chan_en;
    assign array_irq_req   = s_r.req;
    assign cpu_irq         = s_r.irq;
    assign wdt_reset       = s_r.wdt_rst;

endmodule : pca_counter_timebase_irq

// ==== tb/pca_counter_timebase_irq_assertions.sv ====
// Port-level checks of the counter array core
`timescale 1ns/1ps

module pca_counter_timebase_irq_assertions (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // Interrupts and lines
    input wire logic        array_irq_req,
    input wire logic        cpu_irq,
    input wire logic [2:0]  channel_io_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_CPU_IRQ: assert property (cpu_irq |-> array_irq_req)
        else $error("cpu irq without array request");
    // Only a register write may lower the request, never a tick
    AST_IRQ_STICKY: assert property (array_irq_req && s_axi_awready |=> array_irq_req)
        else $error("array request dropped without a write");
    AST_OE_WRITE: assert property (!$stable(channel_io_oe) |-> !s_axi_awready)
        else $error("channel enable changed without a write");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not two edges after take");
    AST_RERR: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
    AST_B_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
endmodule : pca_counter_timebase_irq_assertions

// ==== tb/pca_counter_timebase_irq_tb_top.sv ====
// Self-checking bench of the counter array core
`timescale 1ns/1ps

module pca_counter_timebase_irq_tb_top;
    import pca_pkg::*;
    typedef struct {logic [31:0] exp; int tol; logic [1:0] resp;} exp_s;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, ext_count_input = 1, ext_osc_div8 = 0;
    logic timer0_ovf = 0, cpu_idle = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, array_irq_req, cpu_irq, wdt_reset;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0, channel_io_line, channel_io_oe;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    exp_s expq[$], e;
    int num_errors = 0, total_checks = 0, cyc = 0, t1, n;
    int divs[3] = '{1, 4, 12};
    logic [2:0] modes[3] = '{3'h4, 3'h1, 3'h0};

    always #20 aclk = ~aclk;
    always @(posedge aclk) cyc++;

    pca_counter_timebase_irq dut_u (.*);

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r = 2'h0);
        bit done = 0;
        @(posedge aclk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) begin
                done = 1;
                s_axi_bready <= 0;
                chk("bresp", s_axi_bresp, r);
            end
        end
        if (!done) begin num_errors++; report_and_stop(); end
    endtask : wr

    // Expected value is queued; the monitor below compares it
    task automatic rd(logic [7:0] a, logic [31:0] x, int tol = 0, logic [1:0] r = 2'h0);
        bit done = 0;
        @(posedge aclk);
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        s_axi_araddr <= a;
        expq.push_back('{x, tol, r});
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) begin done = 1; s_axi_rready <= 0; end
        end
        if (!done) begin num_errors++; report_and_stop(); end
    endtask : rd

    always @(posedge aclk) if (s_axi_rvalid && s_axi_rready) begin
        if (expq.size() == 0) chk("read queue", 0, 1);
        else begin
            e = expq.pop_front();
            chk("rresp", s_axi_rresp, e.resp);
            chk("rdata", s_axi_rdata, ((s_axi_rdata - e.exp) <= e.tol) === 1'b1 ?
                s_axi_rdata : e.exp);
        end
    end

    // Counter writes land only while the watchdog enable is clear
    task automatic setcnt(logic [15:0] c);
        wr(8'h04, {24'h0, c[7:0]});
        wr(8'h08, {24'h0, c[15:8]});
    endtask : setcnt

    task automatic t0(int k);
        repeat (k) begin
            @(posedge aclk) timer0_ovf <= 1;
            @(posedge aclk) timer0_ovf <= 0;
        end
    endtask : t0

    // Four cycles low and four high keeps the pin well under a quarter of the clock
    task automatic pins(int k);
        repeat (k) begin
            @(posedge aclk) {ext_count_input, ext_osc_div8} <= 2'b01;
            repeat (4) @(posedge aclk);
            {ext_count_input, ext_osc_div8} <= 2'b10;
            repeat (3) @(posedge aclk);
        end
        repeat (4) @(posedge aclk);
    endtask : pins

    initial begin
        repeat (100000) @(posedge aclk);
        num_errors++;
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(71));
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        @(negedge aclk) chk("awready", s_axi_awready, 1);
        rd(8'h00, 32'h10);
        wr(8'h00, 32'h0);
        wr(8'h00, 32'h6);
        v = $urandom;
        setcnt(v[15:0]);
        rd(8'h04, v[7:0]);
        wr(8'h08, {24'h0, ~v[15:8]});
        rd(8'h08, v[15:8]);
        rd(8'h04, v[7:0]);
        rd(8'h08, {24'h0, ~v[15:8]});
        wr(8'h00, 32'h2);
        setcnt(v[15:0]);
        n = 1 + $urandom % 6;
        t0(n);
        rd(8'h04, 8'(v[15:0] + n));
        t0(n);
        rd(8'h04, 8'(v[15:0] + 2 * n));
        rd(8'h08, 8'((v[15:0] + 2 * n) >> 8));
        rd(8'h40, 32'h0, 0, 2'h2);
        wr(8'h40, 32'h1, 2'h2);
        for (int m = 3; m <= 5; m += 2) begin
            wr(8'h00, m);
            setcnt(16'h0);
            pins(5);
            rd(8'h04, 32'h5);
        end
        foreach (divs[i]) begin
            wr(8'h00, 32'h6);
            setcnt(16'h0);
            t1 = cyc;
            wr(8'h00, {29'h0, modes[i]});
            repeat (120) @(posedge aclk);
            t1 = cyc - t1;
            wr(8'h00, 32'h7);
            rd(8'h04, t1 / divs[i] - 1, 2);
        end
        wr(8'h00, 32'h2);
        setcnt(16'h0);
        @(posedge aclk) cpu_idle <= 1;
        t0(3);
        rd(8'h04, 32'h3);
        wr(8'h00, 32'ha);
        t0(3);
        rd(8'h04, 32'h3);
        @(posedge aclk) cpu_idle <= 0;
        t0(2);
        rd(8'h04, 32'h5);
        wr(8'h00, 32'h2);
        wr(8'h0c, 32'hf);
        setcnt(16'hffff);
        t0(1);
        rd(8'h04, 32'h0);
        rd(8'h0c, 32'h1);
        @(negedge aclk) chk("irq req", array_irq_req, 0);
        wr(8'h10, 32'h1);
        @(negedge aclk) chk("irq req", array_irq_req, 1);
        chk("cpu irq", cpu_irq, 0);
        wr(8'h00, 32'h22);
        @(negedge aclk) chk("cpu irq", cpu_irq, 0);
        wr(8'h00, 32'h62);
        @(negedge aclk) chk("cpu irq", cpu_irq, 1);
        repeat (20) @(posedge aclk);
        rd(8'h0c, 32'h1);
        wr(8'h0c, 32'h1);
        @(negedge aclk) chk("irq req", array_irq_req, 0);
        for (int ch = 0; ch < 3; ch++) begin
            wr(8'h00, 32'h2);
            setcnt(16'h0100);
            wr(8'(8'h14 + 4 * ch), 32'h0102);
            wr(8'h10, 1 << (ch + 1));
            wr(8'h00, 32'h2 | (1 << (8 + ch)));
            t0(2);
            rd(8'h0c, 1 << (ch + 1));
            @(negedge aclk) chk("irq req", array_irq_req, 1);
            chk("oe", channel_io_oe, 1 << ch);
            chk("line", channel_io_line, (1 << (ch + 1)) - 1);
            wr(8'h0c, 32'hf);
        end
        // Mid-run reset: watchdog comes back on and guards its registers
        @(posedge aclk) aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(negedge aclk) chk("awready", s_axi_awready, 1);
        chk("oe", channel_io_oe, 0);
        rd(8'h00, 32'h10);
        wr(8'h1c, 32'h3);
        rd(8'h1c, 32'h0);
        wr(8'h00, 32'h12);
        rd(8'h00, 32'h10);
        wr(8'h00, 32'h6);
        wr(8'h00, 32'h6);
        wr(8'h1c, 32'h3);
        setcnt(16'h0);
        wr(8'h00, 32'h12);
        t0(3);
        @(negedge aclk) chk("wdt", wdt_reset, 1);
        @(negedge aclk) chk("wdt", wdt_reset, 0);
        report_and_stop();
    end
endmodule : pca_counter_timebase_irq_tb_top

bind pca_counter_timebase_irq pca_counter_timebase_irq_assertions checker_u (.*);
